/* hdl/cpusf_pkg.sv */
// Purpose: Constants and types for the CPU status flag register
// Assumes: 8-bit core, one clock
// Notes:   Bit positions, reset values and register index live here
package cpusf_pkg;

   localparam int unsigned CPUSF_W         = 8;
   localparam logic [7:0]  CPUSF_FLAGS_IDX = 8'h0A;
   localparam int unsigned CPUSF_C_BIT     = 0;
   localparam int unsigned CPUSF_HALF_BIT  = 1;
   localparam int unsigned CPUSF_Z_BIT     = 2;
   localparam int unsigned CPUSF_WRAP_BIT  = 3;
   localparam int unsigned CPUSF_PD_BIT    = 4;
   localparam int unsigned CPUSF_WD_BIT    = 5;
   localparam int unsigned CPUSF_CHAIN_BIT = 6;
   localparam int unsigned CPUSF_SXOR_BIT  = 7;
   localparam int unsigned CPUSF_MSB       = 7;
   localparam int unsigned CPUSF_NIB       = 4;
   localparam logic        CPUSF_SYS_RST   = 1'b0;
   localparam logic [7:0]  CPUSF_ARITH_RST = 8'h00;
   localparam logic [7:0]  CPUSF_ZERO      = 8'h00;
   localparam logic [7:0]  CPUSF_RO_MASK   = 8'h30;

   // Operation class presented by the decoder with each executed instruction
   typedef enum logic [3:0] {
      CPUSF_OP_NONE,
      CPUSF_OP_ADD,
      CPUSF_OP_ADDC,
      CPUSF_OP_SUB,
      CPUSF_OP_SUBB,
      CPUSF_OP_LOGIC,
      CPUSF_OP_INCDEC,
      CPUSF_OP_RLC,
      CPUSF_OP_RRC
   } cpusf_op_t;

endpackage

/* hdl/cpusf_flags.sv */
// Purpose: Processor status flag register with ALU flag generation
// Assumes: One instruction completes per cycle while op_valid is high
// Notes:   Software access through a plain address/strobe port
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Carry is set on addition carry out or subtraction without borrow, else cleared.
// - Rotate-through-carry instructions shift the carry bit through and update it.
// - Half carry is set on low-nibble carry out, or no low-nibble borrow when subtracting.
// - Zero is set when the result is zero and cleared otherwise.
// - Signed wrap is carry into the top bit xor carry out of it.
// - Sign-xor is signed wrap xor the top bit of the result.
// - Plain subtract instructions copy the new zero flag into chained zero.
// - Subtract with borrow ANDs the old chained zero with the new zero.
// - All other instructions leave chained zero untouched.
// - Software writes never change the watchdog-expired or power-down bits.
// - Power-down flag clears on reset or watchdog clear and sets on sleep only.
// - Watchdog-expired sets on time-out and clears on reset, watchdog clear or sleep.
// - Flags are never stacked on call or interrupt; no save path exists here.
// - Bits from 7 down: sign-xor, chained zero, watchdog, power-down, wrap, zero, half, carry.
// - After reset all eight flags read 0, the arithmetic flags as well as the two system flags.
module cpusf_flags
   import cpusf_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        op_valid,
   input  wire cpusf_op_t   op_class,
   input  wire logic [7:0]  op_a,
   input  wire logic [7:0]  op_b,
   input  wire logic        watchdog_clear_instruction,
   input  wire logic        sleep_instruction,
   input  wire logic        watchdog_timeout,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic      [7:0]  alu_result,
   output logic      [7:0]  cpu_flags
);

   ////////////////////////////////////////////////////////////////////////////
   // Result and flag computation

   function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci);
      add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
   endfunction

   function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b,
                                       input logic ci);
      add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
   endfunction

   logic [7:0] res;
   logic       c_new;
   logic       half_new;
   logic       wrap_new;
   logic       arith;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] bop;
   logic       cin;
   logic [7:0] low7;
   logic       c7;

   always_comb begin
      bop    = op_b;
      cin    = 1'b0;
      arith  = 1'b0;
      res    = CPUSF_ZERO;
      c_new  = cpu_flags[CPUSF_C_BIT];
      half_new = cpu_flags[CPUSF_HALF_BIT];
      wrap_new = cpu_flags[CPUSF_WRAP_BIT];
      unique case (op_class)
         CPUSF_OP_ADD: begin
            arith = 1'b1;
         end
         CPUSF_OP_ADDC: begin
            arith = 1'b1;
            cin   = cpu_flags[CPUSF_C_BIT];
         end
         CPUSF_OP_SUB: begin
            arith = 1'b1;
            bop   = ~op_b;
            cin   = 1'b1;
         end
         CPUSF_OP_SUBB: begin
            arith = 1'b1;
            bop   = ~op_b;
            cin   = cpu_flags[CPUSF_C_BIT];
         end
         default: begin
         end
      endcase
      sum  = add9(op_a, bop, cin);
      nib  = add5(op_a[3:0], bop[3:0], cin);
      // Carry into the top bit, taken from the low seven bits
      low7 = {1'b0, op_a[6:0]} + {1'b0, bop[6:0]} + {7'h00, cin};
      c7   = low7[CPUSF_MSB];
      if (arith) begin
         res      = sum[7:0];
         c_new    = sum[CPUSF_W];
         half_new = nib[CPUSF_NIB];
         wrap_new = c7 ^ sum[CPUSF_W];
      end
      unique case (op_class)
         CPUSF_OP_LOGIC:  res = op_a;
         CPUSF_OP_INCDEC: res = op_a + op_b;
         CPUSF_OP_RLC: begin
            res   = {op_a[6:0], cpu_flags[CPUSF_C_BIT]};
            c_new = op_a[CPUSF_MSB];
         end
         CPUSF_OP_RRC: begin
            res   = {cpu_flags[CPUSF_C_BIT], op_a[7:1]};
            c_new = op_a[0];
         end
         default: begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next flag state

   logic [7:0] next_cpu_flags;
   logic [7:0] next_alu_result;
   logic [7:0] next_reg_rdata;
   logic       z_new;
   logic       hit_wr;
   logic       hit_rd;
   logic       flag_op;

   assign hit_wr = reg_wr && (reg_addr == CPUSF_FLAGS_IDX);
   assign hit_rd = reg_rd && (reg_addr == CPUSF_FLAGS_IDX);
   assign z_new  = (res == CPUSF_ZERO);

   always_comb begin
      next_cpu_flags  = cpu_flags;
      next_alu_result = alu_result;
      flag_op         = op_valid && (op_class != CPUSF_OP_NONE);
      // Read port and the cpu_flags output are the only ways out; no stack or save path exists
      next_reg_rdata  = hit_rd ? cpu_flags : CPUSF_ZERO;
      // Software write first, then instruction flags override
      if (hit_wr) begin
         next_cpu_flags = (reg_wdata & ~CPUSF_RO_MASK) |
                          (cpu_flags & CPUSF_RO_MASK);
      end
      if (flag_op) begin
         next_alu_result = res;
         next_cpu_flags[CPUSF_Z_BIT] = z_new;
         if (op_class != CPUSF_OP_LOGIC && op_class != CPUSF_OP_INCDEC) begin
            next_cpu_flags[CPUSF_C_BIT] = c_new;
         end
         if (arith) begin
            next_cpu_flags[CPUSF_HALF_BIT] = half_new;
            next_cpu_flags[CPUSF_WRAP_BIT] = wrap_new;
            next_cpu_flags[CPUSF_SXOR_BIT] = wrap_new ^ res[CPUSF_MSB];
         end
         if (op_class == CPUSF_OP_SUB) begin
            next_cpu_flags[CPUSF_CHAIN_BIT] = z_new;
         end else if (op_class == CPUSF_OP_SUBB) begin
            next_cpu_flags[CPUSF_CHAIN_BIT] = cpu_flags[CPUSF_CHAIN_BIT] & z_new;
         end
      end
      // System flags: only these events touch them
      if (op_valid && watchdog_clear_instruction) begin
         next_cpu_flags[CPUSF_PD_BIT] = 1'b0;
         next_cpu_flags[CPUSF_WD_BIT] = 1'b0;
      end else if (op_valid && sleep_instruction) begin
         next_cpu_flags[CPUSF_PD_BIT] = 1'b1;
         next_cpu_flags[CPUSF_WD_BIT] = 1'b0;
      end
      if (watchdog_timeout) begin
         next_cpu_flags[CPUSF_WD_BIT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_flags  <= CPUSF_ARITH_RST;
         alu_result <= CPUSF_ZERO;
         reg_rdata  <= CPUSF_ZERO;
      end else begin
         cpu_flags  <= next_cpu_flags;
         alu_result <= next_alu_result;
         reg_rdata  <= next_reg_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sys_flags_ro_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (hit_wr && !op_valid && !watchdog_timeout) |=>
         ((cpu_flags & CPUSF_RO_MASK) == ($past(cpu_flags) & CPUSF_RO_MASK)))
      else $error("software write changed a system flag");

   pd_on_sleep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && sleep_instruction && !watchdog_clear_instruction) |=>
         cpu_flags[CPUSF_PD_BIT])
      else $error("power-down flag not set by sleep");

   pd_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(op_valid && (sleep_instruction || watchdog_clear_instruction)) |=>
         $stable(cpu_flags[CPUSF_PD_BIT]))
      else $error("power-down flag changed without cause");

   wd_timeout_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      watchdog_timeout |=> cpu_flags[CPUSF_WD_BIT])
      else $error("watchdog flag missed a time-out");

   wd_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && watchdog_clear_instruction && !watchdog_timeout) |=>
         !cpu_flags[CPUSF_WD_BIT] && !cpu_flags[CPUSF_PD_BIT])
      else $error("watchdog clear did not clear system flags");

   wd_sleep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && sleep_instruction && !watchdog_clear_instruction && !watchdog_timeout) |=>
         !cpu_flags[CPUSF_WD_BIT])
      else $error("sleep did not clear the watchdog flag");

   zero_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flag_op |=> (cpu_flags[CPUSF_Z_BIT] == (alu_result == CPUSF_ZERO)))
      else $error("zero flag disagrees with result");

   carry_add_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_ADD) |=>
         cpu_flags[CPUSF_C_BIT] == ({1'b0, $past(op_a)} + {1'b0, $past(op_b)} > 9'h0FF))
      else $error("carry wrong after add");

   carry_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_SUB) |=>
         cpu_flags[CPUSF_C_BIT] == ($past(op_a) >= $past(op_b)))
      else $error("carry wrong after subtract");

   half_add_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_ADD) |=>
         cpu_flags[CPUSF_HALF_BIT] ==
            ({1'b0, $past(op_a[3:0])} + {1'b0, $past(op_b[3:0])} > 5'h0F))
      else $error("half carry wrong after add");

   half_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_SUB) |=>
         cpu_flags[CPUSF_HALF_BIT] == ($past(op_a[3:0]) >= $past(op_b[3:0])))
      else $error("half carry wrong after subtract");

   wrap_add_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_ADD) |=>
         cpu_flags[CPUSF_WRAP_BIT] == (($past(op_a[CPUSF_MSB]) == $past(op_b[CPUSF_MSB])) &&
            (alu_result[CPUSF_MSB] != $past(op_a[CPUSF_MSB]))))
      else $error("signed wrap wrong after add");

   sign_xor_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && arith) |=>
         cpu_flags[CPUSF_SXOR_BIT] == (cpu_flags[CPUSF_WRAP_BIT] ^ alu_result[CPUSF_MSB]))
      else $error("sign-xor flag wrong");

   chain_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_SUB) |=>
         cpu_flags[CPUSF_CHAIN_BIT] == cpu_flags[CPUSF_Z_BIT])
      else $error("chained zero differs from zero after subtract");

   chain_and_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_SUBB && !cpu_flags[CPUSF_CHAIN_BIT]) |=>
         !cpu_flags[CPUSF_CHAIN_BIT])
      else $error("chained zero rose during borrow chain");

   chain_borrow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_SUBB) |=>
         cpu_flags[CPUSF_CHAIN_BIT] ==
            ($past(cpu_flags[CPUSF_CHAIN_BIT]) && cpu_flags[CPUSF_Z_BIT]))
      else $error("chained zero is not old chain and new zero");

   chain_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class != CPUSF_OP_SUB && op_class != CPUSF_OP_SUBB && !hit_wr) |=>
         $stable(cpu_flags[CPUSF_CHAIN_BIT]))
      else $error("chained zero changed by other instruction");

   rot_left_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_RLC) |=>
         (cpu_flags[CPUSF_C_BIT] == $past(op_a[CPUSF_MSB])) &&
         (alu_result == {$past(op_a[6:0]), $past(cpu_flags[CPUSF_C_BIT])}))
      else $error("rotate left through carry wrong");

   rot_right_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_valid && op_class == CPUSF_OP_RRC) |=>
         (cpu_flags[CPUSF_C_BIT] == $past(op_a[0])) &&
         (alu_result == {$past(cpu_flags[CPUSF_C_BIT]), $past(op_a[7:1])}))
      else $error("rotate right through carry wrong");

   rd_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      hit_rd |=> (reg_rdata == $past(cpu_flags)))
      else $error("read data is not the flag byte");

   rd_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !hit_rd |=> (reg_rdata == CPUSF_ZERO))
      else $error("read data not zero without a read");

   flags_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(op_valid || hit_wr || watchdog_timeout) |=> $stable(cpu_flags))
      else $error("flags changed with no instruction, write or time-out");

endmodule
`default_nettype wire

/* verif/cpusf_dec_model.sv */
// Purpose: Decoder and ALU issue model driving the instruction port
// Assumes: One instruction per call, taken at the next rising edge
// Notes:   Released operands are inverted, not held
`timescale 1ns/1ps
`default_nettype none
module cpusf_dec_model
   import cpusf_pkg::*;
(
   input  wire logic       clk_sys,
   output logic            op_valid,
   output var cpusf_op_t   op_class,
   output logic      [7:0] op_a,
   output logic      [7:0] op_b,
   output logic            wd_clear,
   output logic            sleep_op
);
   initial begin
      op_valid = 1'b0;
      op_class = CPUSF_OP_NONE;
      op_a     = 8'h00;
      op_b     = 8'h00;
      wd_clear = 1'b0;
      sleep_op = 1'b0;
   end

   task automatic issue(input cpusf_op_t c, input logic [7:0] a, b, input logic clr, slp);
      op_valid <= 1'b1;
      op_class <= c;
      op_a     <= a;
      op_b     <= b;
      wd_clear <= clr;
      sleep_op <= slp;
      @(posedge clk_sys);
      op_valid <= 1'b0;
      op_class <= CPUSF_OP_NONE;
      op_a     <= ~a;
      op_b     <= ~b;
      wd_clear <= 1'b0;
      sleep_op <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* verif/test_cpu_status_flag_register.sv */
// Purpose: Self-checking bench for the status flag register
// Assumes: Decoder model drives the instruction port
// Notes:   Expected flags are tracked locally in ef
`timescale 1ns/1ps
`default_nettype none
module test_cpu_status_flag_register
   import cpusf_pkg::*;
;
   logic       clk_sys, rst_n, wd_tout, reg_wr, reg_rd, op_valid, clr_op, slp_op;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, alu_result, cpu_flags, op_a, op_b, ef;
   cpusf_op_t  op_class;
   int         fails, n_compared;
   // Operation class, operand a, operand b
   localparam logic [19:0] VEC [13] = '{20'h10F01, 20'h18080, 20'h20101, 20'h17F01,
      20'h30505, 20'h40000, 20'h41001, 20'h40000, 20'h30102, 20'h78100, 20'h80100,
      20'h50000, 20'h6FF01};

   cpusf_flags DUT (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
      .op_class(op_class), .op_a(op_a), .op_b(op_b), .watchdog_clear_instruction(clr_op),
      .sleep_instruction(slp_op), .watchdog_timeout(wd_tout), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .alu_result(alu_result), .cpu_flags(cpu_flags));
   cpusf_dec_model dec (.clk_sys(clk_sys), .op_valid(op_valid), .op_class(op_class),
      .op_a(op_a), .op_b(op_b), .wd_clear(clr_op), .sleep_op(slp_op));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge clk_sys);
   endtask

   // Returns result and next flags
   function automatic logic [15:0] ref_op(cpusf_op_t c, logic [7:0] a, b, f);
      logic [7:0] bb, r, n, lo;
      logic       ci, co;
      n  = f;
      bb = (c == CPUSF_OP_SUB || c == CPUSF_OP_SUBB) ? ~b : b;
      ci = (c == CPUSF_OP_SUB) | ((c == CPUSF_OP_ADDC || c == CPUSF_OP_SUBB) & f[0]);
      {co, r} = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
      lo = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
      if (c inside {CPUSF_OP_ADD, CPUSF_OP_ADDC, CPUSF_OP_SUB, CPUSF_OP_SUBB}) begin
         n[0] = co;
         n[1] = ({1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci}) > 5'h0F;
         n[3] = lo[7] ^ co;
         n[7] = lo[7] ^ co ^ r[7];
      end
      if (c == CPUSF_OP_LOGIC) r = a;
      if (c == CPUSF_OP_INCDEC) r = a + b;
      if (c == CPUSF_OP_RLC) {n[0], r} = {a, f[0]};
      if (c == CPUSF_OP_RRC) {r, n[0]} = {f[0], a};
      n[2] = (r == 8'h00);
      if (c == CPUSF_OP_SUB) n[6] = n[2];
      if (c == CPUSF_OP_SUBB) n[6] = f[6] & n[2];
      return {r, n};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check_sys();
      wr(CPUSF_FLAGS_IDX, 8'hFF);
      chk(cpu_flags, 8'hCF);
      @(posedge clk_sys);
      wd_tout <= 1'b1;
      @(posedge clk_sys);
      wd_tout <= 1'b0;
      #1 chk(cpu_flags, 8'hEF);
      @(posedge clk_sys);
      wr(CPUSF_FLAGS_IDX, 8'h00);
      chk(cpu_flags, 8'h20);
      @(posedge clk_sys);
      wr(8'h0B, 8'hFF);
      chk(cpu_flags, 8'h20);
      @(posedge clk_sys);
      rd(8'h0B, 8'h00);
      rd(CPUSF_FLAGS_IDX, 8'h20);
      dec.issue(CPUSF_OP_NONE, 8'h00, 8'h00, 1'b0, 1'b1);
      #1 chk(cpu_flags, 8'h10);
      @(posedge clk_sys);
      dec.issue(CPUSF_OP_NONE, 8'h00, 8'h00, 1'b1, 1'b0);
      #1 chk(cpu_flags, 8'h00);
      ef = 8'h00;
      @(posedge clk_sys);
   endtask

   task automatic check_alu();
      logic [15:0] e;
      for (int i = 0; i < 13; i++) begin
         e = ref_op(cpusf_op_t'(VEC[i][19:16]), VEC[i][15:8], VEC[i][7:0], ef);
         dec.issue(cpusf_op_t'(VEC[i][19:16]), VEC[i][15:8], VEC[i][7:0], 1'b0, 1'b0);
         ef = e[7:0];
         #1 chk(cpu_flags, ef);
         chk(alu_result, e[15:8]);
         @(posedge clk_sys);
      end
   endtask

   task automatic check_prio();
      logic [15:0] e;
      e = ref_op(CPUSF_OP_ADD, 8'h0F, 8'h01, ef);
      reg_addr  <= CPUSF_FLAGS_IDX;
      reg_wdata <= 8'hCF;
      reg_wr    <= 1'b1;
      dec.issue(CPUSF_OP_ADD, 8'h0F, 8'h01, 1'b0, 1'b0);
      reg_wr    <= 1'b0;
      #1 chk(cpu_flags & 8'h8F, e[7:0] & 8'h8F);
      chk(cpu_flags & 8'h40, 8'h40);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      #1 chk(cpu_flags, 8'h00);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rd(CPUSF_FLAGS_IDX, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      #20000;
      fails++;
      end_sim();
   end

   initial begin
      fails      = 0;
      n_compared = 0;
      rst_n      = 1'b0;
      wd_tout    = 1'b0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      ef         = 8'h00;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1 chk(cpu_flags, 8'h00);
      @(posedge clk_sys);
      check_sys();
      check_alu();
      check_prio();
      end_sim();
   end
endmodule
`default_nettype wire
